// ==== pkg/fpk_pkg.sv ====
// constants and types shared by the front panel keypad and fault display block
`default_nettype none
package fpk_pkg;
  // timing
  localparam int CLK_NS      = 20;
  localparam int DEB_MS      = 10;
  localparam int DBL_MS      = 300;
  localparam int DEB_CYC_DEF = DEB_MS * 1000000 / CLK_NS;
  localparam int DBL_CYC_DEF = DBL_MS * 1000000 / CLK_NS;
  localparam int TMR_W       = 24;
  // register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_NADDR  = 8'h04;
  localparam logic [7:0] A_NBAUD  = 8'h08;
  localparam logic [7:0] A_JOG    = 8'h0C;
  localparam logic [7:0] A_PIDX   = 8'h10;
  localparam logic [7:0] A_PVAL   = 8'h14;
  localparam logic [7:0] A_FAULT  = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_VALUE  = 8'h20;
  localparam logic [7:0] A_KBIT   = 8'h24;
  // field positions
  localparam int CTL_CLR  = 0;
  localparam int CTL_RSEL = 2;
  localparam int ST_BAUD  = 8;
  localparam int ST_ADV   = 16;
  localparam int ST_EDIT  = 17;
  // fault reaction selections
  localparam logic [1:0] RSEL_WARN  = 2'h1;
  localparam logic [1:0] RSEL_COAST = 2'h2;
  // fault numbering, bit n of a vector is fault n
  localparam int NFLT  = 32;
  localparam int F_HS  = 1;
  localparam int F_UV  = 5;
  localparam int F_STO = 27;
  localparam logic [31:0] FLT_USED          = 32'h0800_0BFE;
  localparam logic [31:0] fault_reset_class = 32'h0800_096E;
  localparam logic [31:0] FLT_DET           = 32'h0000_0090;
  localparam logic [31:0] FLT_HARD          = 32'h0000_0294;
  // trip thresholds and display codes
  localparam logic [7:0] HS_TRIP_C = 8'h50;
  localparam logic [9:0] UV_TRIP_V = 10'h064;
  localparam logic [7:0] CARD_CODE = 8'hDE;
  // key entry
  localparam int K_RT = 0;
  localparam int K_LF = 1;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TEN = 16'h000A;
  localparam logic [3:0]  MENU_ONE = 4'h1;
  localparam logic [3:0]  MENU_TWO = 4'h2;
  localparam int NPOS = 16;
  // field-bus baud coding
  localparam int NBAUD = 11;
  localparam logic [7:0] BAUD_CODE [NBAUD] = '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h0C, 8'h19,
                                               8'h21, 8'h32, 8'h42, 8'h50, 8'h64};
  localparam logic [9:0] BAUD_KBIT [NBAUD] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h07D,
                                               10'h0FA, 10'h14D, 10'h1F4, 10'h29A, 10'h320,
                                               10'h3E8};
  typedef enum logic [1:0] {DK_STAT, DK_FAULT, DK_CARD, DK_STO} fpk_dkind_t;
  typedef enum logic [1:0] {RX_NONE, RX_WARN, RX_RAMP, RX_COAST} fpk_react_t;
  typedef struct packed {
    fpk_dkind_t kind;
    logic [7:0] num;
    logic       det_vld;
    logic [7:0] det;
  } fpk_disp_t;
  typedef struct packed {
    logic       vld;
    logic [7:0] addr;
  } fpk_rx_t;
endpackage
`default_nettype wire

// ==== hw/fpk_top.sv ====
// front panel keys, display codes, fault latch and field-bus settings
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fpk_top #(
  parameter int unsigned DEB_CYC = fpk_pkg::DEB_CYC_DEF,
  parameter int unsigned DBL_CYC = fpk_pkg::DBL_CYC_DEF
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  // front keys, right is up, left is down in edit mode and ignored in the menu
  input  wire logic                key_rt,
  input  wire logic                key_lf,
  // saved settings from and to the nonvolatile store
  input  wire logic [7:0]          nv_addr,
  input  wire logic [7:0]          nv_baud,
  output logic [7:0]               save_addr,
  output logic [7:0]               save_baud,
  // setup link addressing
  input  wire fpk_pkg::fpk_rx_t    rx,
  output logic                     rx_accept,
  // drive state and monitors
  input  wire logic                sto1_en,
  input  wire logic                sto2_en,
  input  wire logic                drive_en,
  input  wire logic [7:0]          temp_hs,
  input  wire logic [9:0]          vbus,
  input  wire logic [31:0]         flt_src,
  input  wire logic [7:0]          fault_detail_code,
  input  wire logic                card_err,
  // jog and position
  input  wire logic                jog_plus,
  input  wire logic                jog_minus,
  input  wire logic [31:0]         pos_act,
  // operator outputs
  output fpk_pkg::fpk_disp_t       disp,
  output fpk_pkg::fpk_react_t      react,
  output logic [9:0]               baud_kbit,
  output logic                     baud_ok,
  output logic                     menu_adv,
  output logic                     edit_mode,
  output logic [3:0]               menu_item,
  output logic [15:0]              entry_val,
  output logic                     val_accept,
  output logic signed [15:0]       jog_cmd,
  output logic [15:0]              pos_hit
);
  import fpk_pkg::*;

  function automatic logic [15:0] fpk_step(logic [15:0] v, logic dn, logic ten);
    logic [15:0] d;
    d = ten ? STEP_TEN : STEP_ONE;
    return dn ? v - d : v + d;
  endfunction

  function automatic logic [9:0] fpk_baud(logic [7:0] c);
    logic [9:0] k;
    k = '0;
    for (int i = 0; i < NBAUD; i++) begin
      if (c == BAUD_CODE[i]) begin
        k = BAUD_KBIT[i];
      end
    end
    return k;
  endfunction

  function automatic fpk_react_t fpk_react(logic [4:0] f, logic [1:0] sel);
    if (FLT_HARD[f] || sel == RSEL_COAST) begin
      return RX_COAST;
    end
    if (sel == RSEL_WARN) begin
      return RX_WARN;
    end
    return RX_RAMP;
  endfunction

  // reset release through two flops
  logic rs1_r;
  logic rst_n_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_r   <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rs1_r   <= 1'b1;
      rst_n_r <= rs1_r;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_r);

  // register decode
  wire w_ctrl  = reg_wr && reg_addr == A_CTRL;
  wire w_naddr = reg_wr && reg_addr == A_NADDR;
  wire w_nbaud = reg_wr && reg_addr == A_NBAUD;
  wire w_jog   = reg_wr && reg_addr == A_JOG;
  wire w_pidx  = reg_wr && reg_addr == A_PIDX;
  wire w_pval  = reg_wr && reg_addr == A_PVAL;
  wire clear_fault_command = w_ctrl && reg_wdata[CTL_CLR];

  logic [1:0]         fault_reaction_select;
  logic [7:0]         naddr_r;
  logic [7:0]         nbaud_r;
  logic signed [15:0] jspd_r;
  logic [3:0]         pidx_r;
  logic [31:0]        preg_r [NPOS];
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fault_reaction_select <= '0;
      naddr_r <= '0;
      nbaud_r <= '0;
      jspd_r  <= '0;
      pidx_r  <= '0;
      for (int i = 0; i < NPOS; i++) begin
        preg_r[i] <= '0;
      end
    end else begin
      if (w_ctrl) begin
        fault_reaction_select <= reg_wdata[CTL_RSEL +: 2];
      end
      if (w_naddr) begin
        naddr_r <= reg_wdata[7:0];
      end
      if (w_nbaud) begin
        nbaud_r <= reg_wdata[7:0];
      end
      if (w_jog) begin
        jspd_r <= reg_wdata[15:0];
      end
      if (w_pidx) begin
        pidx_r <= reg_wdata[3:0];
      end
      if (w_pval) begin
        preg_r[pidx_r] <= reg_wdata;
      end
    end
  end

  // settings are caught once after reset; later writes wait for a power cycle
  logic       first_r;
  logic [7:0] act_addr_r;
  logic [7:0] act_baud_r;
  logic       adv_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      first_r    <= 1'b1;
      act_addr_r <= '0;
      act_baud_r <= '0;
      adv_r      <= 1'b0;
    end else begin
      first_r <= 1'b0;
      if (first_r) begin
        act_addr_r <= nv_addr;
        act_baud_r <= nv_baud;
        adv_r      <= key_rt;
      end
    end
  end

  // key debounce
  logic [1:0]       kraw;
  logic [1:0]       kst_r;
  logic [1:0]       kst_d_r;
  logic [TMR_W-1:0] dcnt_r [2];
  assign kraw = {key_lf, key_rt};
  wire [1:0] press = kst_r & ~kst_d_r;
  wire cfm = press[K_LF] && kst_r[K_RT];
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      kst_r   <= '0;
      kst_d_r <= '0;
      dcnt_r  <= '{default: '0};
    end else begin
      kst_d_r <= kst_r;
      for (int k = 0; k < 2; k++) begin
        if (kraw[k] == kst_r[k]) begin
          dcnt_r[k] <= '0;
        end else if (dcnt_r[k] == TMR_W'(DEB_CYC - 1)) begin
          kst_r[k]  <= kraw[k];
          dcnt_r[k] <= '0;
        end else begin
          dcnt_r[k] <= dcnt_r[k] + 1'b1;
        end
      end
    end
  end

  // a press waits out the window to tell a single from a double press
  typedef enum logic {KS_IDLE, KS_WAIT} fpk_ks_t;
  fpk_ks_t          ks_r;
  fpk_ks_t          ks_nxt;
  logic             pk_r;
  logic             pk_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic             app;
  logic             app_ten;
  always_comb begin
    ks_nxt  = ks_r;
    pk_nxt  = pk_r;
    tmr_nxt = tmr_r + 1'b1;
    app     = 1'b0;
    app_ten = 1'b0;
    unique case (ks_r)
      KS_IDLE: begin
        if (!cfm && |press) begin
          ks_nxt  = KS_WAIT;
          pk_nxt  = press[K_LF];
          tmr_nxt = '0;
        end
      end
      KS_WAIT: begin
        if (cfm) begin
          ks_nxt = KS_IDLE;
        end else if (press[pk_r]) begin
          app     = 1'b1;
          app_ten = 1'b1;
          ks_nxt  = KS_IDLE;
        end else if (|press) begin
          app     = 1'b1;
          pk_nxt  = ~pk_r;
          tmr_nxt = '0;
        end else if (tmr_r == TMR_W'(DBL_CYC - 1)) begin
          app    = 1'b1;
          ks_nxt = KS_IDLE;
        end
      end
    endcase
  end

  // a held right key counts as an up press if the window ends before left
  logic        edit_r;
  logic [3:0]  item_r;
  logic [15:0] entry_r;
  logic [15:0] accepted_r;
  logic        acc_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ks_r       <= KS_IDLE;
      pk_r       <= 1'b0;
      tmr_r      <= '0;
      edit_r     <= 1'b0;
      item_r     <= '0;
      entry_r    <= '0;
      accepted_r <= '0;
      acc_r      <= 1'b0;
    end else begin
      ks_r  <= ks_nxt;
      pk_r  <= pk_nxt;
      tmr_r <= tmr_nxt;
      acc_r <= cfm && edit_r;
      if (cfm) begin
        edit_r <= ~edit_r;
        if (edit_r) begin
          accepted_r <= entry_r;
        end
      end
      if (app && edit_r) begin
        entry_r <= fpk_step(entry_r, pk_r, app_ten);
      end else if (app && !pk_r) begin
        item_r <= item_r + (app_ten ? MENU_TWO : MENU_ONE);
      end
    end
  end

  // fault latch; a new event wins over a clear in the same cycle
  logic        sto_d_r;
  logic        den_d_r;
  logic [31:0] flt_r;
  logic [31:0] flt_set;
  logic [4:0]  fidx;
  wire sto_on = sto1_en && sto2_en;
  wire f27 = sto_on && !sto_d_r && drive_en && !den_d_r;
  wire [31:0] clr_m = clear_fault_command ? fault_reset_class : '0;
  always_comb begin
    flt_set        = flt_src;
    flt_set[F_HS]  = flt_src[F_HS] || temp_hs > HS_TRIP_C;
    flt_set[F_UV]  = flt_src[F_UV] || vbus < UV_TRIP_V;
    flt_set[F_STO] = flt_src[F_STO] || f27;
    flt_set        = flt_set & FLT_USED;
  end
  always_comb begin
    fidx = '0;
    for (int i = NFLT - 1; i > 0; i--) begin
      if (flt_r[i]) begin
        fidx = 5'(i);
      end
    end
  end

  // display, reaction and outputs
  fpk_disp_t dnx;
  always_comb begin
    dnx.kind    = DK_STAT;
    dnx.num     = '0;
    dnx.det_vld = 1'b0;
    dnx.det     = '0;
    if (fidx != '0) begin
      dnx.kind    = DK_FAULT;
      dnx.num     = 8'(fidx);
      dnx.det_vld = FLT_DET[fidx];
      dnx.det     = FLT_DET[fidx] ? fault_detail_code : '0;
    end else if (card_err) begin
      dnx.kind = DK_CARD;
      dnx.num  = CARD_CODE;
    end else if (!sto1_en && !sto2_en && !drive_en) begin
      dnx.kind = DK_STO;
    end
  end
  wire fpk_react_t rnx = fidx != '0 ? fpk_react(fidx, fault_reaction_select) : RX_NONE;
  wire signed [15:0] jnx = (jog_plus && !jog_minus) ? jspd_r
                         : (jog_minus && !jog_plus) ? -jspd_r : '0;
  wire rx_hit = rx.vld && act_addr_r != '0 && rx.addr == act_addr_r;

  fpk_disp_t          disp_r;
  fpk_react_t         react_r;
  logic [9:0]         kbit_r;
  logic               bok_r;
  logic               rxa_r;
  logic signed [15:0] jog_r;
  logic [15:0]        hit_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sto_d_r <= 1'b0;
      den_d_r <= 1'b0;
      flt_r   <= '0;
      disp_r  <= '0;
      react_r <= RX_NONE;
      kbit_r  <= '0;
      bok_r   <= 1'b0;
      rxa_r   <= 1'b0;
      jog_r   <= '0;
      hit_r   <= '0;
    end else begin
      sto_d_r <= sto_on;
      den_d_r <= drive_en;
      flt_r   <= (flt_r & ~clr_m) | flt_set;
      disp_r  <= dnx;
      react_r <= rnx;
      kbit_r  <= fpk_baud(act_baud_r);
      bok_r   <= |fpk_baud(act_baud_r);
      rxa_r   <= rx_hit;
      jog_r   <= jnx;
      for (int i = 0; i < NPOS; i++) begin
        hit_r[i] <= pos_act >= preg_r[i];
      end
    end
  end

  // read port, data only in the cycle after the strobe
  logic [31:0] rnxd;
  logic [31:0] rdata_r;
  always_comb begin
    rnxd = '0;
    case (reg_addr)
      A_CTRL:   rnxd[CTL_RSEL +: 2] = fault_reaction_select;
      A_NADDR:  rnxd[7:0] = naddr_r;
      A_NBAUD:  rnxd[7:0] = nbaud_r;
      A_JOG:    rnxd[15:0] = jspd_r;
      A_PIDX:   rnxd[3:0] = pidx_r;
      A_PVAL:   rnxd = preg_r[pidx_r];
      A_FAULT:  rnxd = flt_r;
      A_STATUS: rnxd = {14'h0000, edit_r, adv_r, act_baud_r, act_addr_r};
      A_VALUE:  rnxd[15:0] = accepted_r;
      A_KBIT:   rnxd[9:0] = kbit_r;
      default:  rnxd = '0;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rnxd : '0;
    end
  end

  assign reg_rdata  = rdata_r;
  assign save_addr  = naddr_r;
  assign save_baud  = nbaud_r;
  assign rx_accept  = rxa_r;
  assign disp       = disp_r;
  assign react      = react_r;
  assign baud_kbit  = kbit_r;
  assign baud_ok    = bok_r;
  assign menu_adv   = adv_r;
  assign edit_mode  = edit_r;
  assign menu_item  = item_r;
  assign entry_val  = entry_r;
  assign val_accept = acc_r;
  assign jog_cmd    = jog_r;
  assign pos_hit    = hit_r;

  property p_up_one;
    edit_r && ks_r == KS_WAIT && !pk_r && press == 2'b00 && tmr_r == TMR_W'(DBL_CYC - 1)
      |=> entry_r == $past(entry_r) + STEP_ONE;
  endproperty
  a_up_one: assert property (p_up_one) else $error("single up press missed");

  property p_dn_one;
    edit_r && ks_r == KS_WAIT && pk_r && press == 2'b00 && tmr_r == TMR_W'(DBL_CYC - 1)
      |=> entry_r == $past(entry_r) - STEP_ONE;
  endproperty
  a_dn_one: assert property (p_dn_one) else $error("single down press missed");

  property p_up_ten;
    edit_r && ks_r == KS_WAIT && !pk_r && press == 2'b01 |=> entry_r == $past(entry_r) + STEP_TEN;
  endproperty
  a_up_ten: assert property (p_up_ten) else $error("double up press missed");

  property p_cfm;
    cfm && edit_r |=> val_accept && !edit_mode && accepted_r == $past(entry_r);
  endproperty
  a_cfm: assert property (p_cfm) else $error("confirm not taken");

  property p_menu;
    first_r |=> menu_adv == $past(key_rt) ##1 $stable(menu_adv);
  endproperty
  a_menu: assert property (p_menu) else $error("menu choice not caught");

  property p_hold;
    !first_r |=> $stable(act_addr_r) && $stable(act_baud_r);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed without power cycle");

  property p_rx;
    rx.vld && rx.addr != act_addr_r |=> !rx_accept;
  endproperty
  a_rx: assert property (p_rx) else $error("foreign traffic accepted");

  property p_baud;
    act_baud_r == BAUD_CODE[5] |=> baud_kbit == BAUD_KBIT[5];
  endproperty
  a_baud: assert property (p_baud) else $error("baud decode wrong");

  property p_clr;
    clear_fault_command && flt_set == '0 |=> (flt_r & fault_reset_class) == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");

  property p_hs;
    temp_hs > HS_TRIP_C |=> flt_r[F_HS] ##1 disp.kind == DK_FAULT;
  endproperty
  a_hs: assert property (p_hs) else $error("heat sink trip missed");

  property p_sto;
    disp.kind == DK_STO |-> $past(!drive_en && !sto1_en && !sto2_en);
  endproperty
  a_sto: assert property (p_sto) else $error("sto code while enabled");

  property p_jog;
    !jog_plus && !jog_minus |=> jog_cmd == '0;
  endproperty
  a_jog: assert property (p_jog) else $error("jog runs with button released");
endmodule
`default_nettype wire

// ==== dv/fpk_operator.sv ====
// behavioural operator at the two front keys, contacts chatter on every change
`timescale 1ns/1ns
`default_nettype none
module fpk_operator (
  // clock
  input  wire logic mclk,
  // what the operator means to do with each key
  input  wire logic want_rt,
  input  wire logic want_lf,
  // raw contacts seen by the panel
  output logic      key_rt,
  output logic      key_lf
);
  logic [1:0] want_w;
  logic [1:0] want_r    = 2'h0;
  logic [1:0] key_r     = 2'h0;
  logic [1:0] cnt_r [2] = '{2'h0, 2'h0};
  assign want_w = {want_lf, want_rt};
  assign key_rt = key_r[0];
  assign key_lf = key_r[1];
  // two cycles of bounce after each change, so a key read from one sample is caught
  always @(posedge mclk) begin
    for (int k = 0; k < 2; k++) begin
      if (want_w[k] != want_r[k]) begin
        cnt_r[k] <= 2'h2;
      end else if (cnt_r[k] != 2'h0) begin
        cnt_r[k] <= cnt_r[k] - 2'h1;
      end
      key_r[k] <= (cnt_r[k] != 2'h0) ? ~key_r[k] : want_r[k];
    end
    want_r <= want_w;
  end
endmodule
`default_nettype wire

// ==== dv/fpk_top_tb_top.sv ====
// self-checking bench for the front panel keypad and fault display block
`timescale 1ns/1ns
`default_nettype none
module fpk_top_tb_top;
  import fpk_pkg::*;
  // short debounce and double-press windows keep the run brief
  localparam int DEB = 4;
  localparam int DBL = 20;
  localparam logic [7:0] BC [11] = '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h0C, 8'h19, 8'h21, 8'h32,
                                     8'h42, 8'h50, 8'h64};
  localparam logic [9:0] BK [11] = '{10'h00A, 10'h014, 10'h032, 10'h064, 10'h07D, 10'h0FA,
                                     10'h14D, 10'h1F4, 10'h29A, 10'h320, 10'h3E8};
  logic               mclk              = 1'b0;
  logic               arst_n            = 1'b0;
  logic [7:0]         reg_addr          = 8'h00;
  logic [31:0]        reg_wdata         = 32'h0;
  logic               reg_wr            = 1'b0;
  logic               reg_rd            = 1'b0;
  logic [31:0]        reg_rdata;
  logic [1:0]         want              = 2'h0;
  logic               key_rt;
  logic               key_lf;
  logic [7:0]         nv_addr           = 8'h05;
  logic [7:0]         nv_baud           = 8'h01;
  logic [7:0]         save_addr;
  logic [7:0]         save_baud;
  fpk_rx_t            rx                = '0;
  logic               rx_accept;
  logic               sto1_en           = 1'b1;
  logic               sto2_en           = 1'b1;
  logic               drive_en          = 1'b0;
  logic [7:0]         temp_hs           = 8'h19;
  logic [9:0]         vbus              = 10'h12C;
  logic [31:0]        flt_src           = 32'h0;
  logic [7:0]         fault_detail_code = 8'h00;
  logic               card_err          = 1'b0;
  logic               jog_plus          = 1'b0;
  logic               jog_minus         = 1'b0;
  logic [31:0]        pos_act           = 32'h0;
  fpk_disp_t          disp;
  fpk_react_t         react;
  logic [9:0]         baud_kbit;
  logic               baud_ok;
  logic               menu_adv;
  logic               edit_mode;
  logic [3:0]         menu_item;
  logic [15:0]        entry_val;
  logic               val_accept;
  logic signed [15:0] jog_cmd;
  logic [15:0]        pos_hit;
  int                 fail_count        = 0;
  int                 checks            = 0;
  int                 cyc               = 0;
  int                 acc_n             = 0;
  logic [31:0]        d;
  logic [7:0]         na;
  logic [15:0]        spd;
  logic [31:0]        pv [16];
  fpk_top #(.DEB_CYC(DEB), .DBL_CYC(DBL)) u_dut (
    .mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .key_rt, .key_lf,
    .nv_addr, .nv_baud, .save_addr, .save_baud, .rx, .rx_accept, .sto1_en, .sto2_en,
    .drive_en, .temp_hs, .vbus, .flt_src, .fault_detail_code, .card_err, .jog_plus,
    .jog_minus, .pos_act, .disp, .react, .baud_kbit, .baud_ok, .menu_adv, .edit_mode,
    .menu_item, .entry_val, .val_accept, .jog_cmd, .pos_hit
  );
  fpk_operator u_oper (.mclk, .want_rt(want[K_RT]), .want_lf(want[K_LF]), .key_rt, .key_lf);
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (val_accept === 1'b1) acc_n <= acc_n + 1;
  end
  function automatic logic [9:0] kbit_of(input logic [7:0] c);
    logic [9:0] k;
    k = 10'h000;
    for (int i = 0; i < 11; i++) begin
      if (BC[i] == c) k = BK[i];
    end
    return k;
  endfunction
  function automatic logic [15:0] hit_of(input logic [31:0] p);
    logic [15:0] h;
    for (int i = 0; i < 16; i++) begin
      h[i] = (p >= pv[i]);
    end
    return h;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a hung handshake would otherwise stall the run for good
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("[FAIL] %0t run too long", $time);
      give_verdict();
    end
  end
  task automatic rst();
    @(posedge mclk) arst_n <= 1'b0;
    tick(4);
    @(posedge mclk) arst_n <= 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rxs(input logic [7:0] a, input logic e);
    @(posedge mclk) rx <= '{vld: 1'b1, addr: a};
    @(posedge mclk) rx.vld <= 1'b0;
    #1 chk(rx_accept, e);
  endtask
  // presses of one key, eight cycles down and eight up, then the window runs out
  task automatic key(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) want[k] <= 1'b1;
      tick(7);
      @(posedge mclk) want[k] <= 1'b0;
      tick(7);
    end
    tick(DBL + 20);
  endtask
  task automatic confirm();
    @(posedge mclk) want[K_RT] <= 1'b1;
    tick(12);
    @(posedge mclk) want[K_LF] <= 1'b1;
    tick(10);
    @(posedge mclk) want <= 2'h0;
    tick(DBL + 20);
  endtask
  initial begin
    void'($urandom(98095));
    rst();
    chk(menu_adv, 32'h0);
    key(K_RT, 1);
    chk(menu_item, 32'h1);
    key(K_LF, 1);
    chk(menu_item, 32'h1);
    @(posedge mclk) want[K_RT] <= 1'b1;
    rst();
    chk(menu_adv, 32'h1);
    @(posedge mclk) want[K_RT] <= 1'b0;
    tick(DBL + 20);
    $display("menu test done");
    confirm();
    chk({edit_mode, entry_val}, 32'h10000);
    key(K_RT, 2);
    chk(entry_val, 32'h0A);
    key(K_RT, 1);
    chk(entry_val, 32'h0B);
    key(K_LF, 1);
    chk(entry_val, 32'h0A);
    key(K_LF, 2);
    chk(entry_val, 32'h0);
    key(K_RT, 1);
    confirm();
    chk(acc_n, 32'h1);
    chk(edit_mode, 32'h0);
    rd(A_VALUE, d);
    chk(d, 32'h1);
    $display("entry test done");
    for (int i = 0; i < 12; i++) begin
      nv_baud <= (i < 11) ? BC[i] : 8'h03;
      rst();
      chk({baud_ok, baud_kbit}, {(i < 11), kbit_of(nv_baud)});
    end
    na = 8'($urandom_range(1, 254));
    wr(A_NADDR, {24'h0, na});
    wr(A_NBAUD, 32'h32);
    rd(A_STATUS, d);
    chk(d[15:0], {8'h03, nv_addr});
    chk({save_baud, save_addr}, {8'h32, na});
    nv_addr <= na;
    nv_baud <= 8'h32;
    rst();
    chk(baud_kbit, 32'h1F4);
    rxs(na, 1'b1);
    rxs(~na, 1'b0);
    rxs(8'h00, 1'b0);
    nv_addr <= 8'hFF;
    rst();
    rxs(8'hFF, 1'b1);
    rd(8'h40, d);
    chk(d, 32'h0);
    $display("settings test done");
    temp_hs <= 8'h50;
    vbus <= 10'h064;
    tick(4);
    rd(A_FAULT, d);
    chk(d, 32'h0);
    temp_hs <= 8'($urandom_range(81, 200));
    vbus <= 10'h063;
    tick(4);
    rd(A_FAULT, d);
    chk(d, 32'h22);
    chk({disp.kind, disp.num, react}, {DK_FAULT, 8'h01, RX_RAMP});
    wr(A_CTRL, {28'h0, RSEL_WARN, 2'h0});
    tick(3);
    chk(react, RX_WARN);
    wr(A_CTRL, {28'h0, RSEL_COAST, 2'h0});
    tick(3);
    chk(react, RX_COAST);
    temp_hs <= 8'h19;
    vbus <= 10'h12C;
    wr(A_CTRL, 32'h1);
    tick(3);
    rd(A_FAULT, d);
    chk(d, 32'h0);
    fault_detail_code <= 8'($urandom_range(1, 255));
    flt_src <= 32'h110;
    tick(1);
    flt_src <= 32'h0;
    tick(4);
    chk({disp.num, disp.det_vld, disp.det}, {8'h04, 1'b1, fault_detail_code});
    chk(react, RX_COAST);
    wr(A_CTRL, 32'h1);
    tick(3);
    rd(A_FAULT, d);
    chk(d, 32'h10);
    rst();
    rd(A_FAULT, d);
    chk(d, 32'h0);
    {sto1_en, sto2_en} <= 2'h0;
    tick(4);
    chk(disp.kind, DK_STO);
    drive_en <= 1'b1;
    tick(4);
    chk(disp.kind, DK_STAT);
    drive_en <= 1'b0;
    tick(2);
    {sto1_en, sto2_en, drive_en} <= 3'h7;
    tick(4);
    rd(A_FAULT, d);
    chk(d, 32'h0800_0000);
    drive_en <= 1'b0;
    rst();
    card_err <= 1'b1;
    tick(4);
    chk({disp.kind, disp.num}, {DK_CARD, 8'hDE});
    card_err <= 1'b0;
    $display("fault test done");
    spd = 16'($urandom_range(1, 2000));
    wr(A_JOG, {16'h0, spd});
    jog_plus <= 1'b1;
    tick(3);
    chk({16'h0, jog_cmd}, {16'h0, spd});
    {jog_plus, jog_minus} <= 2'h1;
    tick(3);
    chk({16'h0, jog_cmd}, {16'h0, 16'(-spd)});
    jog_minus <= 1'b0;
    tick(3);
    chk({16'h0, jog_cmd}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      pv[i] = $urandom_range(0, 4000);
      wr(A_PIDX, i);
      wr(A_PVAL, pv[i]);
    end
    for (int i = 0; i < 16; i++) begin
      wr(A_PIDX, i);
      rd(A_PVAL, d);
      chk(d, pv[i]);
      pos_act <= i[0] ? pv[i] : $urandom_range(0, 4000);
      tick(3);
      chk(pos_hit, hit_of(pos_act));
    end
    $display("jog and position test done");
    give_verdict();
  end
endmodule
`default_nettype wire
